// >>> bench/iwh_partner.sv
`timescale 1ns/1ps
`default_nettype none
module iwh_partner (
    input wire logic clock_i,
    input wire logic rst_n_i,
    output logic rc_osc_o,
    output logic phase_two_o
);
    // ****************
    // Core timing.
    // ****************
    logic [2:0] phase;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            phase <= 3'h0;
        end else begin
            phase <= phase + 3'h1;
        end
    end
    // The RC source gives one rising edge every eight clocks.
    assign rc_osc_o = phase[2];
    // One phase-two pulse per four-clock instruction cycle.
    assign phase_two_o = (phase[1:0] == 2'h3);
endmodule
`default_nettype wire

// >>> bench/test_interrupt_watchdog_halt_control.sv
`include "iwh_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_watchdog_halt_control
    import iwh_pkg::*;
;
    // ****************
    // Signals.
    // ****************
    logic clock_i, rst_n_i, ext_n, rc, p2, tmr, sfull, wr, rd;
    logic [7:0] porta, addr, wdata, rdata, vec, d;
    iwh_usb_evt_t usb;
    iwh_instr_t ins;
    logic call, crst, warm, ostop, res, tof, powerdown_flag, sclk;
    logic [3:0] obs;
    int num_errors = 0;
    int check_count = 0;
    int n;
    assign obs = {res, warm, crst, call};
    iwh_partner partner (.clock_i(clock_i), .rst_n_i(rst_n_i), .rc_osc_o(rc), .phase_two_o(p2));
    iwh_top DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .external_reset_pin_n_i(ext_n), .rc_osc_i(rc),
        .porta_i(porta), .usb_evt_i(usb), .timer_overflow_i(tmr), .instr_i(ins), .phase_two_pulse_i(p2),
        .stack_full_i(sfull), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .int_call_o(call), .int_vector_o(vec), .chip_reset_o(crst),
        .warm_reset_o(warm), .osc_stop_o(ostop), .resume_o(res), .timeout_flag_o(tof),
        .powerdown_flag_o(powerdown_flag), .sysclk_select_o(sclk));
    initial begin
        clock_i = 1'h0;
        forever #5 clock_i = ~clock_i;
    end
    // ****************
    // Tasks.
    // ****************
    task automatic tally_and_finish();
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock_i);
        wr = 1'h1;
        addr = a;
        wdata = v;
        @(negedge clock_i);
        wr = 1'h0;
    endtask
    task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock_i);
        rd = 1'h1;
        addr = a;
        @(negedge clock_i);
        rd = 1'h0;
        check(what, rdata, exp);
    endtask
    task automatic pulse(input iwh_usb_evt_t e, input logic t, input iwh_instr_t i);
        @(negedge clock_i);
        usb = e;
        tmr = t;
        ins = i;
        @(negedge clock_i);
        usb = '0;
        tmr = 1'h0;
        ins = '0;
    endtask
    task automatic wait_for(input int b, input int limit, input bit must, output int cnt);
        cnt = 0;
        while (cnt < limit && obs[b] !== 1'h1) begin
            @(negedge clock_i);
            cnt++;
        end
        if (must && cnt >= limit) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    task automatic in_range(input string what, input int v, input int lo, input int hi);
        check(what, 8'(v >= lo && v <= hi), 8'h01);
    endtask
    // ****************
    // Sequence.
    // ****************
    localparam logic [7:0] STAT_EXP [5] = '{8'h04, 8'h08, 8'h01, 8'h01, 8'h02};
    initial begin
        {rst_n_i, ext_n, tmr, sfull, wr, rd} = 6'h10;
        porta = 8'hFF;
        {addr, wdata} = 16'h0000;
        usb = '0;
        ins = '0;
        repeat (16) @(negedge clock_i);
        rst_n_i = 1'h1;
        repeat (4) @(negedge clock_i);
        expect_reg("interrupt_control_reset", `IWH_ADDR_INTERRUPT_CONTROL, `IWH_RST_INTERRUPT_CONTROL);
        expect_reg("watchdog_setup_reset", `IWH_ADDR_WATCHDOG_SETUP, `IWH_RST_WATCHDOG_SETUP);
        expect_reg("unmapped", 8'h7F, 8'h00);
        check("sysclk_default", 8'(sclk), 8'h01);
        reg_write(`IWH_ADDR_CLK_CFG, 8'h00);
        @(negedge clock_i);
        check("sysclk_6mhz", 8'(sclk), 8'h00);
        reg_write(`IWH_ADDR_CLK_CFG, 8'h01);
        sfull = 1'h1;
        reg_write(`IWH_ADDR_INTERRUPT_CONTROL, 8'hFF);
        expect_reg("interrupt_control_gaps", `IWH_ADDR_INTERRUPT_CONTROL, 8'h5B);
        reg_write(`IWH_ADDR_INTERRUPT_CONTROL, 8'h00);
        sfull = 1'h0;
        reg_write(`IWH_ADDR_WATCHDOG_SETUP, 8'hFF);
        expect_reg("watchdog_setup_ff", `IWH_ADDR_WATCHDOG_SETUP, 8'h87);
        reg_write(`IWH_ADDR_WATCHDOG_SETUP, 8'h7A);
        expect_reg("watchdog_setup_7a", `IWH_ADDR_WATCHDOG_SETUP, 8'h82);
        reg_write(`IWH_ADDR_WATCHDOG_SETUP, 8'h87);
        for (int i = 0; i < 5; i++) begin
            pulse(5'h01 << i, 1'h0, '0);
            expect_reg("usb_request", `IWH_ADDR_INTERRUPT_CONTROL, 8'h10);
            expect_reg("event_bit", (i < 3) ? `IWH_ADDR_USB_STAT : `IWH_ADDR_FIFO_STAT, STAT_EXP[i]);
            reg_write((i < 3) ? `IWH_ADDR_USB_STAT : `IWH_ADDR_FIFO_STAT, 8'h00);
            reg_write(`IWH_ADDR_INTERRUPT_CONTROL, 8'h00);
            expect_reg("fw_clear", (i < 3) ? `IWH_ADDR_USB_STAT : `IWH_ADDR_FIFO_STAT, 8'h00);
        end
        pulse(5'h04, 1'h1, '0);
        expect_reg("flags_masked", `IWH_ADDR_INTERRUPT_CONTROL, 8'h50);
        reg_write(`IWH_ADDR_INTERRUPT_CONTROL, 8'h5B);
        wait_for(0, 12, 1, n);
        check("usb_first", vec, `IWH_VEC_USB);
        expect_reg("after_usb", `IWH_ADDR_INTERRUPT_CONTROL, 8'h4A);
        pulse('0, 1'h0, 6'h10);
        wait_for(0, 12, 0, n);
        check("plain_return", 8'(n), 8'h0C);
        pulse('0, 1'h0, 6'h20);
        wait_for(0, 12, 1, n);
        check("timer_vec", vec, `IWH_VEC_TMR);
        expect_reg("after_tmr", `IWH_ADDR_INTERRUPT_CONTROL, 8'h0A);
        sfull = 1'h1;
        pulse('0, 1'h1, '0);
        reg_write(`IWH_ADDR_INTERRUPT_CONTROL, 8'h4B);
        wait_for(0, 12, 0, n);
        check("stack_full", 8'(n), 8'h0C);
        sfull = 1'h0;
        wait_for(0, 12, 1, n);
        check("after_pop", vec, `IWH_VEC_TMR);
        reg_write(`IWH_ADDR_INTERRUPT_CONTROL, 8'h00);
        reg_write(`IWH_ADDR_USB_STAT, 8'h00);
        reg_write(`IWH_ADDR_WATCHDOG_SETUP, 8'h81);
        pulse('0, 1'h0, 6'h04);
        wait_for(1, 1500, 0, n);
        pulse('0, 1'h0, 6'h04);
        wait_for(1, 5000, 1, n);
        in_range("wdt_period", n, 4080, 4110);
        repeat (2) @(negedge clock_i);
        check("timeout_set", 8'(tof), 8'h01);
        expect_reg("chip_reset_interrupt_control", `IWH_ADDR_INTERRUPT_CONTROL, 8'h00);
        pulse('0, 1'h0, 6'h08);
        check("halt_flags", 8'({ostop, powerdown_flag, tof}), 8'h06);
        porta = 8'hFE;
        wait_for(3, 1100, 1, n);
        in_range("port_wake", n, 1020, 1045);
        porta = 8'hFF;
        check("running", 8'(ostop), 8'h00);
        pulse('0, 1'h1, '0);
        pulse('0, 1'h0, 6'h08);
        pulse('0, 1'h1, '0);
        repeat (20) @(negedge clock_i);
        check("preset_no_wake", 8'(ostop), 8'h01);
        pulse(5'h04, 1'h0, '0);
        wait_for(3, 1100, 1, n);
        in_range("int_wake", n, 1020, 1045);
        reg_write(`IWH_ADDR_INTERRUPT_CONTROL, 8'h00);
        reg_write(`IWH_ADDR_USB_STAT, 8'h00);
        reg_write(`IWH_ADDR_WATCHDOG_SETUP, 8'h80);
        pulse('0, 1'h0, 6'h08);
        wait_for(2, 2300, 1, n);
        in_range("warm_period", n, 2030, 2070);
        check("warm_flags", 8'({crst, tof}), 8'h01);
        wait_for(3, 1100, 1, n);
        reg_write(`IWH_ADDR_INTERRUPT_CONTROL, 8'h0B);
        ext_n = 1'h0;
        wait_for(1, 10, 1, n);
        repeat (4) @(negedge clock_i);
        ext_n = 1'h1;
        repeat (6) @(negedge clock_i);
        expect_reg("ext_reset_interrupt_control", `IWH_ADDR_INTERRUPT_CONTROL, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> src/iwh_map.svh
`ifndef IWH_MAP_SVH
`define IWH_MAP_SVH
// ****************************************
// Register addresses in data memory.
// ****************************************
`define IWH_ADDR_INTERRUPT_CONTROL 8'h0B
`define IWH_ADDR_WATCHDOG_SETUP 8'h09
`define IWH_ADDR_FIFO_STAT 8'h1C
`define IWH_ADDR_USB_STAT 8'h1D
`define IWH_ADDR_CLK_CFG 8'h1E
// ****************************************
// Field positions.
// ****************************************
`define IWH_BIT_GIE 0
`define IWH_BIT_USB_EN 1
`define IWH_BIT_TMR_EN 3
`define IWH_BIT_USB_REQ 4
`define IWH_BIT_TMR_REQ 6
`define IWH_BIT_SUSPEND 0
`define IWH_BIT_BUS_RESET 2
`define IWH_BIT_RESUME 3
`define IWH_BIT_SYSCLK 0
`define IWH_WATCHDOG_SETUP_FLAG_HI 7
`define IWH_WATCHDOG_SETUP_FLAG_LO 3
// ****************************************
// Reset values, patterns and vectors.
// ****************************************
`define IWH_RST_INTERRUPT_CONTROL 8'h00
`define IWH_RST_WATCHDOG_SETUP 8'h87
`define IWH_WATCHDOG_SETUP_FLAG_PATTERN 5'h10
`define IWH_RST_CLK_CFG 8'h01
`define IWH_VEC_USB 8'h04
`define IWH_VEC_TMR 8'h0C
// ****************************************
// Timing counts.
// ****************************************
`define IWH_WAKE_DELAY_TSYS 1024
`define IWH_WDT_BASE_DIV 256
`define IWH_INSTR_DIV 4
`endif

// >>> src/iwh_pkg.sv
package iwh_pkg;
    typedef enum logic [1:0] {
        IWH_RUN = 2'b00,
        IWH_HALTED = 2'b01,
        IWH_WAKING = 2'b10
    } iwh_state_t;
    typedef struct packed {
        logic [1:0] fifo_access;
        logic suspend;
        logic resume;
        logic bus_reset;
    } iwh_usb_evt_t;
    typedef struct packed {
        logic return_enabling_ints;
        logic plain_return;
        logic halt;
        logic watchdog_clear_instr;
        logic watchdog_clear_first;
        logic watchdog_clear_second;
    } iwh_instr_t;
endpackage

// >>> src/iwh_top.sv
// Operation
// - USB events set USB request flag bit4
// - USB service calls 04H, clears flag, GIE
// - FIFO access sets endpoint status bit
// - Suspend sets bit0, resume bit3, interrupt
// - Bus reset sets flag and interrupt
// - Timer overflow sets bit6, calls 0CH
// - Return-with-enable sets GIE, plain return not
// - Requests serviced on next phase-two pulse
// - USB beats timer; GIE masks both
// - Flags stay set; enables gate service only
// - Watchdog clock option RC or sysclk/4
// - Watchdog base divides by 256
// - Prescale select gives 1:1 to 1:128
// - User flags accept only pattern 10000
// - Overflow: chip reset in RUN, warm in HALT or wake-up
// - Reset, HALT or clear instructions clear watchdog
// - HALT stops oscillator, sets powerdown, clears timeout
// - Wake by reset, interrupt, watchdog, port A
// - Pre-set flag does not wake device
// - Wake-up inserts 1024-cycle delay
// - Enables at bits 0,1,3; gaps read zero
// - Stack full blocks every acknowledgement
`include "iwh_map.svh"
`timescale 1ns/1ps
`default_nettype none
module iwh_top
    import iwh_pkg::*;
#(
    parameter bit WDT_ENABLE = 1'b1,
    parameter bit WDT_SRC_RC = 1'b1,
    parameter bit CLR_TWICE = 1'b0,
    parameter logic [7:0] PORTA_WAKE_MASK = 8'hFF
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic external_reset_pin_n_i,
    input wire logic rc_osc_i,
    input wire logic [7:0] porta_i,
    input wire iwh_usb_evt_t usb_evt_i,
    input wire logic timer_overflow_i,
    input wire iwh_instr_t instr_i,
    input wire logic phase_two_pulse_i,
    input wire logic stack_full_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic int_call_o,
    output logic [7:0] int_vector_o,
    output logic chip_reset_o,
    output logic warm_reset_o,
    output logic osc_stop_o,
    output logic resume_o,
    output logic timeout_flag_o,
    output logic powerdown_flag_o,
    output logic sysclk_select_o
);
    // ****************************************
    // Pin synchronisers and filtering.
    // ****************************************
    logic [9:0] sync1, sync2, sync3, pins;
    logic [9:0] next_pins;
    always_ff @(posedge clock_i) begin
        sync1 <= {external_reset_pin_n_i, rc_osc_i, porta_i};
        sync2 <= sync1;
        sync3 <= sync2;
    end
    always_comb begin
        next_pins = pins;
        for (int i = 0; i < 10; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_pins[i] = sync3[i];
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pins <= 10'h3FF;
        end else begin
            pins <= next_pins;
        end
    end
    logic ext_rst, rc_rise, porta_wake;
    assign ext_rst = !pins[9];
    assign rc_rise = next_pins[8] && !pins[8];
    assign porta_wake = |(pins[7:0] & ~next_pins[7:0] & PORTA_WAKE_MASK);
    // ****************************************
    // Registers and state.
    // ****************************************
    iwh_state_t state;
    logic gie, usb_en, tmr_en, usb_req, tmr_req;
    logic [1:0] fifo_stat;
    logic suspend_f, resume_f, bus_reset_f;
    logic [7:0] watchdog_setup, clk_cfg;
    logic [14:0] wdt_cnt;
    logic [1:0] div4;
    logic clr_first_seen, clr_second_seen;
    logic [10:0] wake_cnt;
    logic usb_set, tmr_set, ack_usb, ack_tmr, sys_rst;
    logic wdt_tick, wdt_over, wdt_clear, clr_done, wake;
    logic [14:0] wdt_limit;
    logic wr_interrupt_control, wr_usc;
    assign wr_interrupt_control = reg_wr_i && reg_addr_i == `IWH_ADDR_INTERRUPT_CONTROL;
    assign wr_usc = reg_wr_i && reg_addr_i == `IWH_ADDR_USB_STAT;
    assign usb_set = |usb_evt_i.fifo_access || usb_evt_i.suspend
        || usb_evt_i.resume || usb_evt_i.bus_reset;
    assign tmr_set = timer_overflow_i;
    // ****************************************
    // Interrupt acknowledge.
    // ****************************************
    always_comb begin
        ack_usb = 1'b0;
        ack_tmr = 1'b0;
        if (state == IWH_RUN && phase_two_pulse_i && gie && !stack_full_i) begin
            if (usb_req && usb_en) begin
                ack_usb = 1'b1;
            end else if (tmr_req && tmr_en) begin
                ack_tmr = 1'b1;
            end
        end
    end
    assign sys_rst = ext_rst || (wdt_over && state == IWH_RUN);
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || sys_rst) begin
            gie <= 1'b0;
            usb_en <= 1'b0;
            tmr_en <= 1'b0;
        end else begin
            if (wr_interrupt_control) begin
                gie <= reg_wdata_i[`IWH_BIT_GIE];
                usb_en <= reg_wdata_i[`IWH_BIT_USB_EN];
                tmr_en <= reg_wdata_i[`IWH_BIT_TMR_EN];
            end
            if (ack_usb || ack_tmr) begin
                gie <= 1'b0;
            end else if (instr_i.return_enabling_ints) begin
                gie <= 1'b1;
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || sys_rst) begin
            usb_req <= 1'b0;
            tmr_req <= 1'b0;
        end else begin
            if (usb_set) begin
                usb_req <= 1'b1;
            end else if (ack_usb) begin
                usb_req <= 1'b0;
            end else if (wr_interrupt_control) begin
                usb_req <= reg_wdata_i[`IWH_BIT_USB_REQ];
            end
            if (tmr_set) begin
                tmr_req <= 1'b1;
            end else if (ack_tmr) begin
                tmr_req <= 1'b0;
            end else if (wr_interrupt_control) begin
                tmr_req <= reg_wdata_i[`IWH_BIT_TMR_REQ];
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            int_call_o <= 1'b0;
            int_vector_o <= 8'h00;
        end else begin
            int_call_o <= ack_usb || ack_tmr;
            if (ack_usb) begin
                int_vector_o <= `IWH_VEC_USB;
            end else if (ack_tmr) begin
                int_vector_o <= `IWH_VEC_TMR;
            end
        end
    end
    // ****************************************
    // USB status flags.
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || sys_rst) begin
            fifo_stat <= 2'b00;
            suspend_f <= 1'b0;
            resume_f <= 1'b0;
            bus_reset_f <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (usb_evt_i.fifo_access[i]) begin
                    fifo_stat[i] <= 1'b1;
                end else if (reg_wr_i && reg_addr_i == `IWH_ADDR_FIFO_STAT) begin
                    fifo_stat[i] <= reg_wdata_i[i];
                end
            end
            suspend_f <= usb_evt_i.suspend
                || (wr_usc ? reg_wdata_i[`IWH_BIT_SUSPEND] : suspend_f);
            resume_f <= usb_evt_i.resume
                || (wr_usc ? reg_wdata_i[`IWH_BIT_RESUME] : resume_f);
            bus_reset_f <= usb_evt_i.bus_reset
                || (wr_usc ? reg_wdata_i[`IWH_BIT_BUS_RESET] : bus_reset_f);
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            clk_cfg <= `IWH_RST_CLK_CFG;
        end else if (reg_wr_i && reg_addr_i == `IWH_ADDR_CLK_CFG) begin
            clk_cfg <= {7'h00, reg_wdata_i[`IWH_BIT_SYSCLK]};
        end
    end
    // ****************************************
    // Watchdog.
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || sys_rst) begin
            watchdog_setup <= `IWH_RST_WATCHDOG_SETUP;
        end else if (reg_wr_i && reg_addr_i == `IWH_ADDR_WATCHDOG_SETUP) begin
            watchdog_setup[2:0] <= reg_wdata_i[2:0];
            if (reg_wdata_i[`IWH_WATCHDOG_SETUP_FLAG_HI:`IWH_WATCHDOG_SETUP_FLAG_LO] == `IWH_WATCHDOG_SETUP_FLAG_PATTERN) begin
                watchdog_setup[`IWH_WATCHDOG_SETUP_FLAG_HI:`IWH_WATCHDOG_SETUP_FLAG_LO] <= `IWH_WATCHDOG_SETUP_FLAG_PATTERN;
            end
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || state != IWH_RUN) begin
            div4 <= 2'b00;
        end else begin
            div4 <= div4 + 2'b01;
        end
    end
    assign wdt_tick = WDT_ENABLE && (WDT_SRC_RC ? rc_rise
        : (state == IWH_RUN && div4 == 2'(`IWH_INSTR_DIV - 1)));
    assign wdt_limit = (15'(`IWH_WDT_BASE_DIV) << watchdog_setup[2:0]) - 15'd1;
    assign wdt_over = wdt_tick && wdt_cnt == wdt_limit;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || sys_rst || wdt_clear) begin
            clr_first_seen <= 1'b0;
            clr_second_seen <= 1'b0;
        end else begin
            if (instr_i.watchdog_clear_first) begin
                clr_first_seen <= 1'b1;
            end
            if (instr_i.watchdog_clear_second) begin
                clr_second_seen <= 1'b1;
            end
        end
    end
    assign clr_done = WDT_ENABLE && (CLR_TWICE
        ? ((clr_first_seen || instr_i.watchdog_clear_first)
            && (clr_second_seen || instr_i.watchdog_clear_second))
        : instr_i.watchdog_clear_instr);
    assign wdt_clear = clr_done || (instr_i.halt && state == IWH_RUN);
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || ext_rst || wdt_clear || wdt_over) begin
            wdt_cnt <= 15'h0000;
        end else if (wdt_tick) begin
            wdt_cnt <= wdt_cnt + 15'd1;
        end
    end
    // ****************************************
    // HALT and wake-up.
    // ****************************************
    assign wake = porta_wake || (usb_set && !usb_req)
        || (tmr_set && !tmr_req) || wdt_over;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || ext_rst) begin
            state <= IWH_RUN;
            wake_cnt <= 11'h000;
        end else begin
            unique case (state)
                IWH_RUN: begin
                    if (instr_i.halt) begin
                        state <= IWH_HALTED;
                    end
                end
                IWH_HALTED: begin
                    if (wake) begin
                        state <= IWH_WAKING;
                        wake_cnt <= 11'h000;
                    end
                end
                IWH_WAKING: begin
                    wake_cnt <= wake_cnt + 11'd1;
                    if (wake_cnt == 11'(`IWH_WAKE_DELAY_TSYS - 1)) begin
                        state <= IWH_RUN;
                    end
                end
                default: begin
                    state <= IWH_RUN;
                end
            endcase
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            timeout_flag_o <= 1'b0;
            powerdown_flag_o <= 1'b0;
        end else if (wdt_over) begin
            timeout_flag_o <= 1'b1;
        end else if (instr_i.halt && state == IWH_RUN) begin
            timeout_flag_o <= 1'b0;
            powerdown_flag_o <= 1'b1;
        end else if (clr_done) begin
            timeout_flag_o <= 1'b0;
            powerdown_flag_o <= 1'b0;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            chip_reset_o <= 1'b0;
            warm_reset_o <= 1'b0;
            osc_stop_o <= 1'b0;
            resume_o <= 1'b0;
            sysclk_select_o <= 1'b1;
        end else begin
            chip_reset_o <= sys_rst;
            warm_reset_o <= wdt_over && state != IWH_RUN;
            osc_stop_o <= (state == IWH_HALTED && !wake)
                || (state == IWH_RUN && instr_i.halt && !ext_rst);
            resume_o <= state == IWH_WAKING && wake_cnt == 11'(`IWH_WAKE_DELAY_TSYS - 1);
            sysclk_select_o <= clk_cfg[`IWH_BIT_SYSCLK];
        end
    end
    // ****************************************
    // Register read port.
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `IWH_ADDR_INTERRUPT_CONTROL: reg_rdata_o <= {1'b0, usb_req ? 1'b0 : 1'b0, 1'b0, 1'b0, 4'h0}
                    | {1'b0, tmr_req, 1'b0, usb_req, tmr_en, 1'b0, usb_en, gie};
                `IWH_ADDR_WATCHDOG_SETUP: reg_rdata_o <= watchdog_setup;
                `IWH_ADDR_FIFO_STAT: reg_rdata_o <= {6'h00, fifo_stat};
                `IWH_ADDR_USB_STAT: reg_rdata_o <= {4'h0, resume_f, bus_reset_f, 1'b0, suspend_f};
                `IWH_ADDR_CLK_CFG: reg_rdata_o <= clk_cfg;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end
    // ****************************************
    // Checks.
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    property p_usb_flag;
        usb_set && !sys_rst |=> usb_req;
    endproperty
    a_usb_flag: assert property (p_usb_flag) else $error("USB event did not set flag.");
    property p_usb_vec;
        ack_usb |=> int_call_o && int_vector_o == 8'h04 && !gie && (!usb_req || $past(usb_set));
    endproperty
    a_usb_vec: assert property (p_usb_vec) else $error("USB call wrong.");
    property p_tmr_vec;
        ack_tmr |=> int_call_o && int_vector_o == 8'h0C && !gie;
    endproperty
    a_tmr_vec: assert property (p_tmr_vec) else $error("Timer call wrong.");
    property p_prio;
        phase_two_pulse_i && state == IWH_RUN && gie && !stack_full_i && usb_req && usb_en
            |-> !ack_tmr && ack_usb;
    endproperty
    a_prio: assert property (p_prio) else $error("Priority wrong.");
    property p_no_ack;
        (stack_full_i || !gie || !phase_two_pulse_i) |=> !int_call_o;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("Blocked call taken.");
    property p_return_enabling_ints;
        instr_i.return_enabling_ints && !ack_usb && !ack_tmr && !sys_rst |=> gie;
    endproperty
    a_return_enabling_ints: assert property (p_return_enabling_ints) else $error("Return did not enable.");
    property p_halt;
        state == IWH_RUN && instr_i.halt && !wdt_over && !ext_rst
            |=> powerdown_flag_o && !timeout_flag_o && wdt_cnt == 15'h0000;
    endproperty
    a_halt: assert property (p_halt) else $error("HALT entry wrong.");
    property p_wake_delay;
        state == IWH_HALTED && wake && !ext_rst |=> (state == IWH_WAKING) [*8];
    endproperty
    a_wake_delay: assert property (p_wake_delay) else $error("Wake delay short.");
    logic [10:0] chk_wake_cycles;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || state != IWH_WAKING) begin
            chk_wake_cycles <= 11'h000;
        end else begin
            chk_wake_cycles <= chk_wake_cycles + 11'd1;
        end
    end
    property p_wake_end;
        resume_o |-> chk_wake_cycles == 11'(`IWH_WAKE_DELAY_TSYS);
    endproperty
    a_wake_end: assert property (p_wake_end) else $error("Wake delay length wrong.");
    property p_wake_bound;
        state == IWH_WAKING |-> chk_wake_cycles < 11'(`IWH_WAKE_DELAY_TSYS);
    endproperty
    a_wake_bound: assert property (p_wake_bound) else $error("Wake delay too long.");
    property p_wdt_rst;
        wdt_over && state == IWH_RUN |=> chip_reset_o && timeout_flag_o;
    endproperty
    a_wdt_rst: assert property (p_wdt_rst) else $error("Watchdog reset wrong.");
    property p_flags;
        usb_evt_i.suspend && !sys_rst |=> suspend_f;
    endproperty
    a_flags: assert property (p_flags) else $error("Suspend not flagged.");
    c_usb: cover property (ack_usb);
    c_tmr: cover property (ack_tmr);
    c_wake: cover property (resume_o);
    c_warm: cover property (warm_reset_o);
endmodule
`default_nettype wire
